/* logic/tx_flow_setup.sv */
// Purpose: Transmit flow-control setup vectors, pause frame requests and
//          an AXI4-Lite register port for quanta timing and status.
// Assumes: All inputs are on aclk; frame builder takes requests by
//          valid/ready at its next transmit opportunity.
// Notes:   Lane 0 of the quanta bus carries the legacy pause quanta.
// Operation
// - Expose configuration and status as vectors
// - Apply vectors at frame end, flow control immediately
// - Transmit vector 80 bits, 368 with PFC
// - Receive vector 80 bits, 96 with PFC
// - Two-bit status output vector
// - Bits above 79 exist only with PFC
// - Legacy pause refreshes at legacy refresh count
// - Auto resume sends zero quanta on release
// - Per-priority quanta placed in PFC frames
// - Per-priority refresh regenerates PFC frames
// - Priority request honoured only when enabled
// - PFC pause needs bit 80 set; pending resumes still go out
// - Priority request yields frame at next opportunity
// - Legacy request needs bit 5, else ignored
`timescale 1ns/1ps
`default_nettype none
module tx_flow_setup
   import flowctl_pkg::*;
#(
   parameter bit PFC_INCLUDED = 1'b1,
   parameter int TX_W = PFC_INCLUDED ? flowctl_pkg::TX_PFC_W
                                     : flowctl_pkg::TX_BASE_W,
   parameter int RX_W = PFC_INCLUDED ? flowctl_pkg::RX_PFC_W
                                     : flowctl_pkg::RX_BASE_W
)(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Setup and status vectors
   input wire logic [TX_W-1:0] tx_setup_vector,
   input wire logic [RX_W-1:0] rx_setup_vector,
   output logic [flowctl_pkg::STATUS_W-1:0] status_vector,
   output logic [flowctl_pkg::TX_BASE_W-1:0] applied_tx_setup,
   output logic [RX_W-1:0] applied_rx_setup,
   // Frame boundary from the transmitter
   input wire logic frame_busy_in,
   // Pause requests
   input wire logic pause_request_in,
   input wire logic [flowctl_pkg::QUANTA_W-1:0] pause_quanta_in,
   input wire logic prio0_pause_request_in,
   input wire logic prio1_pause_request_in,
   input wire logic prio2_pause_request_in,
   input wire logic prio3_pause_request_in,
   input wire logic prio4_pause_request_in,
   input wire logic prio5_pause_request_in,
   input wire logic prio6_pause_request_in,
   input wire logic prio7_pause_request_in,
   // Flow control frame request to the transmitter
   output logic fc_valid,
   input wire logic fc_ready,
   output logic fc_is_pfc,
   output logic [flowctl_pkg::NUM_PRIO-1:0] fc_prio_mask,
   output logic [flowctl_pkg::NUM_PRIO*flowctl_pkg::QUANTA_W-1:0] fc_quanta,
   // AXI4-Lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int NSRC = NUM_PRIO + 1;
   localparam int LEG = NUM_PRIO;
   // Every assertion below runs on aclk and rests during reset
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Widths must match the feature option
   if (TX_W != (PFC_INCLUDED ? TX_PFC_W : TX_BASE_W) ||
       RX_W != (PFC_INCLUDED ? RX_PFC_W : RX_BASE_W)) begin : g_bad_w
      $error("setup vector widths do not match PFC option");
   end

   // Full-width view; upper bits read as zero without PFC
   logic [TX_PFC_W-1:0] tx_full;
   if (PFC_INCLUDED) begin : g_pfc
      assign tx_full = tx_setup_vector;
   end else begin : g_nopfc
      assign tx_full = {{(TX_PFC_W-TX_BASE_W){1'b0}},
                        tx_setup_vector[TX_BASE_W-1:0]};
   end

   // Flow-control fields act live; bits 87:82 are never decoded
   logic pfc_en_w, auto_resume_w, leg_en_w;
   logic [NUM_PRIO-1:0] prio_req_w, prio_en_w;
   logic [QUANTA_W-1:0] quanta_w [NSRC];
   logic [QUANTA_W-1:0] refresh_w [NSRC];
   assign pfc_en_w = PFC_INCLUDED & tx_full[BIT_PFC_EN];
   assign auto_resume_w = PFC_INCLUDED & tx_full[BIT_AUTO_RESUME];
   assign leg_en_w = tx_full[BIT_LEGACY_FC_EN];
   assign prio_req_w = {prio7_pause_request_in, prio6_pause_request_in,
                        prio5_pause_request_in, prio4_pause_request_in,
                        prio3_pause_request_in, prio2_pause_request_in,
                        prio1_pause_request_in, prio0_pause_request_in};
   assign quanta_w[LEG] = pause_quanta_in;
   assign refresh_w[LEG] = tx_full[FLD_LEGACY_REFRESH_LO +: QUANTA_W];

   // Quanta tick from the software-set divider
   logic [15:0] ctrl_div_ff, div_cnt_ff, nxt_div_cnt, div_last;
   logic quanta_tick;
   assign div_last = (ctrl_div_ff == '0) ? '0 : 16'(ctrl_div_ff - 1'b1);
   assign quanta_tick = (div_cnt_ff >= div_last);
   assign nxt_div_cnt = quanta_tick ? '0 : 16'(div_cnt_ff + 1'b1);

   // Trackers: eight priorities and the legacy source
   logic [NSRC-1:0] pend_pause, pend_resume, src_active, src_en, src_req;
   logic [NSRC-1:0] grant_pause, grant_resume, refresh_on;
   for (genvar i = 0; i < NSRC; i++) begin : g_src
      if (i < NUM_PRIO) begin : g_prio
         // Field pair i sits on a 32-bit pitch; pair 3 is 223:192
         assign prio_en_w[i] = pfc_en_w & tx_full[BIT_PRIO_EN_LO + i];
         assign quanta_w[i] =
            tx_full[FLD_PRIO_QUANTA_LO + i*FLD_PRIO_PITCH +: QUANTA_W];
         assign refresh_w[i] =
            tx_full[FLD_PRIO_REFRESH_LO + i*FLD_PRIO_PITCH +: QUANTA_W];
         assign src_en[i] = prio_en_w[i];
         assign src_req[i] = prio_req_w[i];
         assign refresh_on[i] = 1'b1;
      end else begin : g_leg
         assign src_en[i] = leg_en_w;
         assign src_req[i] = pause_request_in;
         assign refresh_on[i] = PFC_INCLUDED;
      end
      pause_refresh_tracker u_trk (
         .aclk(aclk),
         .aresetn(aresetn),
         .enable(src_en[i]),
         .request(src_req[i]),
         .auto_resume(auto_resume_w),
         .refresh_on(refresh_on[i]),
         .refresh_value(refresh_w[i]),
         .quanta_tick(quanta_tick),
         .grant_pause(grant_pause[i]),
         .grant_resume(grant_resume[i]),
         .pause_pending(pend_pause[i]),
         .resume_pending(pend_resume[i]),
         .active(src_active[i])
      );
   end

   // Frame builder: priorities go first in one PFC frame, legacy after
   logic fc_valid_ff, fc_pfc_ff;
   logic [NUM_PRIO-1:0] fc_mask_ff;
   logic [NUM_PRIO*QUANTA_W-1:0] fc_quanta_ff, prio_lanes;
   logic [NUM_PRIO-1:0] prio_pend;
   logic build, build_pfc;
   assign prio_pend = pend_pause[NUM_PRIO-1:0] | pend_resume[NUM_PRIO-1:0];
   assign build_pfc = |prio_pend;
   assign build = (~fc_valid_ff | fc_ready)
                & (build_pfc | pend_pause[LEG] | pend_resume[LEG]);
   for (genvar i = 0; i < NUM_PRIO; i++) begin : g_lane
      // Resume frames carry zero quanta
      assign prio_lanes[i*QUANTA_W +: QUANTA_W] =
         pend_pause[i] ? quanta_w[i] : '0;
   end
   assign grant_pause = build ? (build_pfc ? {1'b0, pend_pause[NUM_PRIO-1:0]}
                       : {pend_pause[LEG], {NUM_PRIO{1'b0}}}) : '0;
   assign grant_resume = build ? (build_pfc ? {1'b0, pend_resume[NUM_PRIO-1:0]}
                        : {pend_resume[LEG], {NUM_PRIO{1'b0}}}) : '0;

   // Frame request registers; a request holds until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fc_valid_ff <= 1'b0;
         fc_pfc_ff <= 1'b0;
         fc_mask_ff <= '0;
         fc_quanta_ff <= '0;
      end else if (build) begin
         fc_valid_ff <= 1'b1;
         fc_pfc_ff <= build_pfc;
         fc_mask_ff <= build_pfc ? prio_pend : '0;
         fc_quanta_ff <= build_pfc ? prio_lanes
            : {{((NUM_PRIO-1)*QUANTA_W){1'b0}},
               (pend_pause[LEG] ? quanta_w[LEG] : 16'h0000)};
      end else if (fc_ready) begin
         fc_valid_ff <= 1'b0;
      end
   end
   assign fc_valid = fc_valid_ff;
   assign fc_is_pfc = fc_pfc_ff;
   assign fc_prio_mask = fc_mask_ff;
   assign fc_quanta = fc_quanta_ff;

   // Other setup bits change only between frames
   logic [TX_BASE_W-1:0] applied_tx_ff;
   logic [RX_W-1:0] applied_rx_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         applied_tx_ff <= '0;
         applied_rx_ff <= '0;
      end else if (!frame_busy_in) begin
         applied_tx_ff <= tx_full[TX_BASE_W-1:0];
         applied_rx_ff <= rx_setup_vector;
      end
   end
   assign applied_tx_setup = applied_tx_ff;
   assign applied_rx_setup = applied_rx_ff;

   // Status: frame request waiting, any pause source active
   logic [STATUS_W-1:0] status_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_ff <= '0;
      end else begin
         status_ff <= {|src_active, fc_valid_ff};
      end
   end
   assign status_vector = status_ff;

   // AXI4-Lite write: address and data taken in either order
   logic aw_ff, w_ff, bvalid_ff, ar_ok, aw_ok;
   logic [3:0] awaddr_ff, wstrb_ff;
   logic [31:0] wdata_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff, rd_mux;
   logic do_write;
   assign s_axi_awready = ~aw_ff & ~bvalid_ff;
   assign s_axi_wready = ~w_ff & ~bvalid_ff;
   assign do_write = aw_ff & w_ff & ~bvalid_ff;
   assign aw_ok = (awaddr_ff == REG_CTRL) | (awaddr_ff == REG_STATUS);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         ctrl_div_ff <= CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb; // Strobes belong to the data beat
         end
         if (do_write) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= aw_ok ? RESP_OKAY : RESP_SLVERR;
            if (awaddr_ff == REG_CTRL && wstrb_ff[0]) begin
               ctrl_div_ff[7:0] <= wdata_ff[7:0];
            end
            if (awaddr_ff == REG_CTRL && wstrb_ff[1]) begin
               ctrl_div_ff[15:8] <= wdata_ff[15:8];
            end
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   // AXI4-Lite read; status bits are live pending flags
   assign s_axi_arready = ~rvalid_ff;
   assign ar_ok = (s_axi_araddr == REG_CTRL) | (s_axi_araddr == REG_STATUS);
   assign rd_mux = (s_axi_araddr == REG_CTRL) ? {16'h0000, ctrl_div_ff}
      : (s_axi_araddr == REG_STATUS) ? {5'h00, fc_valid_ff, status_ff,
                                        6'h00, pend_resume, pend_pause}
      : 32'h0000_0000;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
         div_cnt_ff <= '0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
         if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= ar_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // Checks on the frame request side
   AST_PFC_GATED: assert property (build && build_pfc |->
      pfc_en_w || |pend_resume[NUM_PRIO-1:0])
      else $error("PFC pause frame built while PFC disabled");
   AST_MASK_ENABLED: assert property ($rose(pend_pause[0]) |->
      $past(prio_en_w[0]))
      else $error("priority 0 pause raised while disabled");
   AST_LANE0_QUANTA: assert property (build && build_pfc
      && pend_pause[0] |=> fc_quanta_ff[QUANTA_W-1:0] == $past(quanta_w[0]))
      else $error("priority 0 quanta not placed in frame");
   AST_HOLD_UNTIL_TAKEN: assert property (fc_valid_ff && !fc_ready
      |=> fc_valid_ff && $stable(fc_quanta_ff) && $stable(fc_mask_ff))
      else $error("frame request changed before taken");
   AST_PRIO_SERVED: assert property (prio_en_w[0] && prio_req_w[0]
      && !src_active[0] && !fc_valid_ff && !(|pend_pause) && !(|pend_resume)
      ##1 prio_en_w[0] && prio_req_w[0]
      |=> fc_valid_ff && fc_pfc_ff && fc_mask_ff[0])
      else $error("priority request not served in two cycles");
   AST_LEGACY_NEEDS_EN: assert property ($rose(pend_pause[LEG]) |->
      $past(leg_en_w))
      else $error("legacy pause raised with flow control disabled");
   AST_RESUME_ZERO: assert property (build && !build_pfc
      && !pend_pause[LEG] |=> !fc_pfc_ff
      && fc_quanta_ff[QUANTA_W-1:0] == 16'h0000)
      else $error("resume frame carries nonzero quanta");
   AST_APPLY_AT_BOUNDARY: assert property (frame_busy_in |=>
      $stable(applied_tx_ff) && $stable(applied_rx_ff))
      else $error("setup applied during a frame");
endmodule : tx_flow_setup
`default_nettype wire

/* logic/flowctl_pkg.sv */
// Purpose: Shared constants for the transmit flow-control setup block.
// Assumes: 50 MHz aclk, AXI4-Lite register access, 32-bit data.
// Notes:   Field positions are bit indices into the transmit setup vector.
`default_nettype none
package flowctl_pkg;
   // Vector widths with and without priority flow control
   localparam int TX_BASE_W = 80;
   localparam int TX_PFC_W = 368;
   localparam int RX_BASE_W = 80;
   localparam int RX_PFC_W = 96;
   localparam int STATUS_W = 2;
   localparam int NUM_PRIO = 8;
   localparam int QUANTA_W = 16;
   // Transmit setup field positions
   localparam int BIT_LEGACY_FC_EN = 5;
   localparam int BIT_PFC_EN = 80;
   localparam int BIT_AUTO_RESUME = 81;
   localparam int BIT_PRIO_EN_LO = 88;
   localparam int FLD_PRIO_QUANTA_LO = 96;
   localparam int FLD_PRIO_REFRESH_LO = 112;
   localparam int FLD_PRIO_PITCH = 32;
   localparam int FLD_LEGACY_REFRESH_LO = 352;
   // Pause quantum is 512 bit times at 10 Gb/s
   localparam int QUANTUM_PS = 51200;
   localparam int CLK_PERIOD_PS = 20000;
   localparam int QUANTUM_CYC = (QUANTUM_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Register map, byte addresses
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [15:0] CTRL_RESET = 16'(QUANTUM_CYC);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : flowctl_pkg
`default_nettype wire

/* logic/pause_refresh_tracker.sv */
// Purpose: Tracks one pause source and asks for pause or resume frames.
// Assumes: Request comes from logic on aclk; no synchroniser needed.
// Notes:   A pending flag is set by an event and cleared by its grant.
`timescale 1ns/1ps
`default_nettype none
module pause_refresh_tracker
   import flowctl_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Settings and request
   input wire logic enable,
   input wire logic request,
   input wire logic auto_resume,
   input wire logic refresh_on,
   input wire logic [flowctl_pkg::QUANTA_W-1:0] refresh_value,
   input wire logic quanta_tick,
   // Grants from the frame builder
   input wire logic grant_pause,
   input wire logic grant_resume,
   // Pending requests
   output logic pause_pending,
   output logic resume_pending,
   output logic active
);
   logic req_d_ff, held_ff, pause_ff, resume_ff;
   logic [QUANTA_W-1:0] count_ff;
   logic req_ok, rise, fall, hit;
   logic nxt_held, nxt_pause, nxt_resume;
   logic [QUANTA_W-1:0] nxt_count;

   // Event decode
   assign req_ok = enable & request;
   assign rise = req_ok & ~req_d_ff;
   assign fall = ~req_ok & req_d_ff;
   assign hit = req_ok & refresh_on & ~pause_ff & ~rise
              & (refresh_value != '0) & (count_ff == refresh_value);
   // Held more than one cycle qualifies a resume frame
   assign nxt_held = req_ok & req_d_ff;
   // Set wins over the grant so no event is lost
   assign nxt_pause = rise | hit | (pause_ff & ~grant_pause & req_ok);
   assign nxt_resume = (fall & held_ff & auto_resume)
                     | (resume_ff & ~grant_resume & ~req_ok);
   // Quanta since the last pause frame; stops once the refresh point is hit
   assign nxt_count = (grant_pause | rise | ~req_ok) ? '0 :
      (quanta_tick && count_ff != refresh_value) ?
      QUANTA_W'(count_ff + 1'b1) : count_ff;

   // State registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_d_ff <= 1'b0;
         held_ff <= 1'b0;
         pause_ff <= 1'b0;
         resume_ff <= 1'b0;
         count_ff <= '0;
      end else begin
         req_d_ff <= req_ok;
         held_ff <= nxt_held;
         pause_ff <= nxt_pause;
         resume_ff <= nxt_resume;
         count_ff <= nxt_count;
      end
   end

   assign pause_pending = pause_ff;
   assign resume_pending = resume_ff;
   assign active = req_d_ff;

   AST_REFRESH_HIT: assert property (@(posedge aclk)
      disable iff (!aresetn) hit |=> pause_ff)
      else $error("refresh point reached without pause request");
endmodule : pause_refresh_tracker
`default_nettype wire

/* verif/fc_sink_model.sv */
// Purpose: Transmitter model that takes flow-control frame requests.
// Assumes: Requests follow valid/ready on aclk.
// Notes:   Stall holds ready low, as a transmitter busy mid-frame would.
`timescale 1ns/1ps
`default_nettype none
module fc_sink_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Frame request from the block
   input wire logic fc_valid,
   output logic fc_ready,
   input wire logic fc_is_pfc,
   input wire logic [flowctl_pkg::NUM_PRIO-1:0] fc_prio_mask,
   input wire logic [flowctl_pkg::NUM_PRIO*flowctl_pkg::QUANTA_W-1:0] fc_quanta,
   // Bench control and capture
   input wire logic stall,
   output logic [7:0] taken_ff,
   output logic [136:0] last_ff
);
   import flowctl_pkg::*;
   // No transmit opportunity while stalled
   assign fc_ready = !stall;
   // Capture each frame at the edge it is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         taken_ff <= 8'h00;
         last_ff <= '0;
      end else if (fc_valid && fc_ready) begin
         taken_ff <= taken_ff + 8'h01;
         last_ff <= {fc_is_pfc, fc_prio_mask, fc_quanta};
      end
   end
endmodule : fc_sink_model
`default_nettype wire

/* verif/tb_tx_flow_setup.sv */
// Purpose: Self-checking bench for the transmit flow-control setup block.
// Assumes: 50 MHz aclk, synchronous active-low reset held 5 cycles.
// Notes:   Frames are judged from what the transmitter model captured.
`timescale 1ns/1ps
`default_nettype none
module tb_tx_flow_setup;
   import flowctl_pkg::*;
   logic aclk, aresetn, busy, lreq, stall, fc_valid, fc_ready, fc_is_pfc;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [367:0] tv;
   logic [95:0] rv, app_rx;
   logic [79:0] app_tx;
   logic [15:0] lq;
   logic [7:0] preq, taken, fc_mask;
   logic [136:0] last;
   logic [127:0] fc_q;
   logic [1:0] stat, bresp, rresp;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   int n_mismatch, comparisons, nf, cyc;

   tx_flow_setup DUT (.aclk(aclk), .aresetn(aresetn),
      .tx_setup_vector(tv), .rx_setup_vector(rv), .status_vector(stat),
      .applied_tx_setup(app_tx), .applied_rx_setup(app_rx),
      .frame_busy_in(busy), .pause_request_in(lreq), .pause_quanta_in(lq),
      .prio0_pause_request_in(preq[0]), .prio1_pause_request_in(preq[1]),
      .prio2_pause_request_in(preq[2]), .prio3_pause_request_in(preq[3]),
      .prio4_pause_request_in(preq[4]), .prio5_pause_request_in(preq[5]),
      .prio6_pause_request_in(preq[6]), .prio7_pause_request_in(preq[7]),
      .fc_valid(fc_valid), .fc_ready(fc_ready), .fc_is_pfc(fc_is_pfc),
      .fc_prio_mask(fc_mask), .fc_quanta(fc_q),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   fc_sink_model partner (.aclk(aclk), .aresetn(aresetn),
      .fc_valid(fc_valid), .fc_ready(fc_ready), .fc_is_pfc(fc_is_pfc),
      .fc_prio_mask(fc_mask), .fc_quanta(fc_q), .stall(stall),
      .taken_ff(taken), .last_ff(last));

   // Free-running 50 MHz clock
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   function automatic logic [15:0] qv(input int k);
      return 16'(16'h1000 + 16'h0111 * k);
   endfunction : qv

   function automatic logic [127:0] lane(input int k);
      return 128'(qv(k)) << (16 * k);
   endfunction : lane

   task automatic end_of_test();
      $display("counts: %0d compared, %0d mismatched", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input logic [136:0] seen, input logic [136:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick

   task automatic done(input string s);
      $display("test %0s finished", s);
   endtask : done

   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
      while (aw_p || w_p) begin
         @(posedge aclk);
         if (aw_p && awready) begin
            aw_p = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_p && wready) begin
            w_p = 1'b0;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      check(bresp, er);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                     input logic [31:0] m, input logic [1:0] er);
      @(posedge aclk);
      {araddr, arvalid} <= {a, 1'b1};
      do @(posedge aclk); while (!arready);
      {arvalid, rready} <= 2'b01;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      check(rresp, er);
      check(rdata & m, ed);
   endtask : rd

   // Setup vector; b is {legacy enable, auto resume, pfc enable}
   task automatic setv(input logic [7:0] en, input logic [2:0] b,
                       input logic [15:0] rf);
      logic [367:0] v;
      v = '0; // Reserved 87:82 stay zero bits 80 and 5 apart
      v[BIT_PFC_EN] = b[0];
      v[BIT_AUTO_RESUME] = b[1];
      v[BIT_LEGACY_FC_EN] = b[2];
      v[BIT_PRIO_EN_LO +: 8] = en;
      v[FLD_LEGACY_REFRESH_LO +: 16] = rf;
      for (int k = 0; k < 8; k++) begin
         v[FLD_PRIO_QUANTA_LO + FLD_PRIO_PITCH * k +: 16] = qv(k);
         v[FLD_PRIO_REFRESH_LO + FLD_PRIO_PITCH * k +: 16] = rf;
      end
      @(posedge aclk);
      tv <= v;
   endtask : setv

   task automatic frame(input logic pfc, input logic [7:0] m,
                        input logic [127:0] q);
      nf++;
      do @(posedge aclk); while (taken != nf[7:0]);
      check(last, {pfc, m, q});
   endtask : frame

   task automatic quiet();
      tick(12);
      check(taken, nf[7:0]);
   endtask : quiet

   // Pending refreshes may still be in flight after a source stops
   task automatic resync();
      tick(12);
      nf = int'(taken);
   endtask : resync

   initial begin
      {aresetn, busy, lreq, stall, awvalid, wvalid, bready} = '0;
      {arvalid, rready, preq, tv, rv, lq, awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      {n_mismatch, comparisons, nf, cyc} = '0;
      tick(5);
      aresetn <= 1'b1;
      rd(REG_CTRL, 32'(CTRL_RESET), 32'h0000FFFF, RESP_OKAY);
      rd(4'h8, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
      wr(4'hC, 32'h5, RESP_SLVERR);
      wr(REG_CTRL, 32'h1, RESP_OKAY);
      rd(REG_CTRL, 32'h1, 32'h0000FFFF, RESP_OKAY);
      done("registers");
      // Every priority, first disabled then enabled
      for (int i = 0; i < 8; i++) begin
         setv(8'h00, 3'b001, 16'h0000);
         preq <= 8'h01 << i;
         quiet();
         preq <= 8'h00;
         setv(8'h01 << i, 3'b001, 16'h0000);
         preq <= 8'h01 << i;
         frame(1'b1, 8'h01 << i, lane(i));
         preq <= 8'h00;
      end
      setv(8'h01, 3'b000, 16'h0000);
      preq <= 8'h01;
      quiet();
      preq <= 8'h00;
      done("priorities");
      setv(8'h00, 3'b100, 16'h0000);
      {lq, lreq} <= {16'h00AB, 1'b1};
      frame(1'b0, 8'h00, 128'h00AB);
      lreq <= 1'b0;
      setv(8'h00, 3'b000, 16'h0000);
      lreq <= 1'b1;
      quiet();
      lreq <= 1'b0;
      done("legacy");
      setv(8'h04, 3'b011, 16'h0000);
      preq <= 8'h04;
      frame(1'b1, 8'h04, lane(2));
      preq <= 8'h00;
      frame(1'b1, 8'h04, 128'h0);
      preq <= 8'h04;
      @(posedge aclk);
      preq <= 8'h00;
      frame(1'b1, 8'h04, lane(2));
      quiet();
      done("auto resume");
      setv(8'h02, 3'b001, 16'h0004);
      preq <= 8'h02;
      frame(1'b1, 8'h02, lane(1));
      frame(1'b1, 8'h02, lane(1));
      setv(8'h00, 3'b000, 16'h0000);
      preq <= 8'h00;
      resync();
      setv(8'h00, 3'b110, 16'h0004);
      lreq <= 1'b1;
      frame(1'b0, 8'h00, 128'h00AB);
      frame(1'b0, 8'h00, 128'h00AB);
      lreq <= 1'b0;
      frame(1'b0, 8'h00, 128'h0);
      setv(8'h00, 3'b000, 16'h0000);
      resync();
      done("refresh");
      // Mid-frame: flow control acts at once, other setup waits
      {busy, stall, rv} <= {2'b11, 96'h5A};
      setv(8'h01, 3'b001, 16'h0000);
      preq <= 8'h01;
      tick(8);
      tv[4] <= 1'b1; // A non-flow-control bit must wait for the frame end
      check(fc_valid, 1'b1);
      check(stat, 2'b11);
      check(app_rx, 96'h0);
      rd(REG_STATUS, 32'h07000000, 32'hFFFFFFFF, RESP_OKAY);
      check(app_tx, 80'h0);
      {busy, stall} <= 2'b00;
      frame(1'b1, 8'h01, lane(0));
      tick(3);
      check(app_rx, 96'h5A);
      check(app_tx, 80'h10);
      done("frame boundary");
      end_of_test();
   end
endmodule : tb_tx_flow_setup
`default_nettype wire
